// ### hdl/rlc_color_pwm.sv
// colour led pwm control: registers, frame timer, slot engine, sink drive
// assumes register strobes come from the serial interface on core_clk_in
// and that the external dimming pin is asynchronous
// What this block does
// R01 - sink mode bit 5: 1 switch, 0 current
// R02 - pwm drives outputs only with bits 7,6 set
// R03 - bit 6 low keeps all outputs off
// R04 - bits 3,2,1 enable red, green, blue
// R05 - bit 0 picks overlapping when set
// R06 - colour code 7:4, brightness code 3:1
// R07 - brightness log: off, 1/64, doubling to full
// R08 - colour code selects fifteen fixed proportions, codes 8 and 9 alike
// R09 - colour proportions only in non-overlapping mode
// R10 - overlapping: enabled outputs on together, duty
// R11 - non-overlapping: scaled red, green, blue slots
// R12 - pwm off: enable bits switch outputs directly
// R13 - sink mode resets to switch mode
// R14 - current codes in 5:4, 3:2, 1:0
// R15 - current code gives quarter steps of full
// R16 - external dimming input is active high
// R17 - pwm passes only while external input high
// R18 - free counter frame, updates at frame edge
// R19 - other bits reset to zero, outputs off
module rlc_color_pwm
  import rlc_pkg::*;
#(
  parameter int FRAME_CYCLES = RLC_FRAME_CYC // cycles per pwm frame
) (
  input wire logic core_clk_in, // core clock, 40 MHz
  input wire logic rst_n_in, // async reset, active low
  input wire logic [7:0] reg_addr_in, // register offset
  input wire logic [7:0] reg_wdata_in, // write data
  input wire logic reg_wr_in, // write strobe
  input wire logic reg_rd_in, // read strobe
  output logic [7:0] reg_rdata_out, // read data, one cycle after strobe
  input wire logic ext_dim_in, // external dimming pin
  input wire logic [2:0] ext_dim_sel_in, // dimming select, red green blue
  output logic red_sink_out, // red sink on
  output logic green_sink_out, // green sink on
  output logic blue_sink_out, // blue sink on
  output logic sink_mode_out, // 1 switch, 0 constant current
  output logic [2:0] red_current_quarters_out, // red current in quarters
  output logic [2:0] green_current_quarters_out, // green current in quarters
  output logic [2:0] blue_current_quarters_out // blue current in quarters
);
  // ==========================================
  // functions
  // colour code to red, green, blue percent (64 = 100, 4B = 75, 32 = 50, 21 = 33, 19 = 25)
  function automatic logic [20:0] color_pct(input logic [3:0] code);
    logic [20:0] v;
    v = 21'h0;
    case (code)
      4'h0: v = {7'h64, 7'h00, 7'h00};
      4'h1: v = {7'h00, 7'h64, 7'h00};
      4'h2: v = {7'h00, 7'h00, 7'h64};
      4'h3: v = {7'h32, 7'h32, 7'h00};
      4'h4: v = {7'h00, 7'h32, 7'h32};
      4'h5: v = {7'h32, 7'h00, 7'h32};
      4'h6: v = {7'h21, 7'h21, 7'h21};
      4'h7: v = {7'h32, 7'h19, 7'h19};
      4'h8: v = {7'h19, 7'h32, 7'h19};
      4'h9: v = {7'h19, 7'h32, 7'h19};
      4'hA: v = {7'h19, 7'h19, 7'h32};
      4'hB: v = {7'h4B, 7'h19, 7'h00};
      4'hC: v = {7'h00, 7'h4B, 7'h19};
      4'hD: v = {7'h19, 7'h4B, 7'h00};
      4'hE: v = {7'h00, 7'h19, 7'h4B};
      4'hF: v = {7'h19, 7'h00, 7'h4B};
      default: v = 21'h0;
    endcase
    return v;
  endfunction

  // share of the frame, scaled by the log brightness code
  function automatic logic [RLC_CNT_W-1:0] scaled_len(input logic [6:0] pct,
                                                      input logic [2:0] code);
    int full;
    full = (int'(pct) * FRAME_CYCLES) / RLC_PCT_FULL;
    if (code == 3'h0) begin
      return '0;
    end
    return RLC_CNT_W'(full >> (RLC_BRIGHT_MAX - int'(code)));
  endfunction

  // current code to quarters of full scale
  function automatic logic [2:0] quarters(input logic [1:0] code);
    return {1'b0, code} + 3'h1;
  endfunction

  // ==========================================
  // registers
  logic [7:0] ctrl_r; // color_output_control
  logic [7:0] color_r; // color_and_brightness
  logic [7:0] curr_r; // channel_current_level

  // software writes, reserved bits masked
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r <= RLC_CTRL_RST; // see R13 see R19
      color_r <= RLC_COLOR_RST; // see R19
      curr_r <= RLC_CURR_RST; // see R19
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        RLC_ADDR_CTRL: ctrl_r <= reg_wdata_in & RLC_CTL_MASK;
        RLC_ADDR_COLOR: color_r <= reg_wdata_in & RLC_COLOR_MASK; // see R06
        RLC_ADDR_CURR: curr_r <= reg_wdata_in & RLC_CURR_MASK; // see R14
        default: ; // unmapped writes ignored
      endcase
    end
  end

  // registered read, unmapped offsets read zero
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        RLC_ADDR_CTRL: reg_rdata_out <= ctrl_r;
        RLC_ADDR_COLOR: reg_rdata_out <= color_r;
        RLC_ADDR_CURR: reg_rdata_out <= curr_r;
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ==========================================
  // frame timer
  logic [RLC_CNT_W-1:0] frame_cnt_r; // position in the frame
  logic frame_end; // last cycle of a frame
  assign frame_end = (frame_cnt_r == RLC_CNT_W'(FRAME_CYCLES - 1));

  // free-running count, wraps each frame
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frame_cnt_r <= '0;
    end else if (frame_end) begin
      frame_cnt_r <= '0; // see R18
    end else begin
      frame_cnt_r <= frame_cnt_r + 1'b1;
    end
  end

  // pwm settings held for a whole frame
  logic pwm_act_r; // internal pwm mode for this frame
  logic ovl_r; // overlap mode for this frame
  logic [3:0] color_q_r; // colour code for this frame
  logic [2:0] bright_q_r; // brightness code for this frame

  // take new settings at the frame edge only
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwm_act_r <= 1'b0;
      ovl_r <= 1'b0;
      color_q_r <= 4'h0;
      bright_q_r <= 3'h0;
    end else if (frame_end) begin
      pwm_act_r <= ctrl_r[RLC_CTL_PWM_BIT]; // see R18
      ovl_r <= ctrl_r[RLC_CTL_OVL_BIT]; // see R05
      color_q_r <= color_r[RLC_COLOR_LSB +: 4];
      bright_q_r <= color_r[RLC_BRIGHT_LSB +: 3];
    end
  end

  // ==========================================
  // slot engine
  logic [20:0] pct; // percent triple for the colour
  logic [RLC_CNT_W-1:0] red_len; // red slot length
  logic [RLC_CNT_W-1:0] green_end; // end of green slot
  logic [RLC_CNT_W-1:0] blue_end; // end of blue slot
  logic [RLC_CNT_W-1:0] duty_len; // overlapping on-time
  logic [2:0] pwm_on; // internal pwm per channel, red green blue

  // slot edges from colour and brightness
  always_comb begin
    pct = color_pct(color_q_r); // see R08
    red_len = scaled_len(pct[20:14], bright_q_r); // see R07
    green_end = red_len + scaled_len(pct[13:7], bright_q_r);
    blue_end = green_end + scaled_len(pct[6:0], bright_q_r);
    duty_len = scaled_len(7'h64, bright_q_r); // see R07
    if (ovl_r) begin
      pwm_on = {3{frame_cnt_r < duty_len}}; // see R10 see R09
    end else begin
      pwm_on[2] = frame_cnt_r < red_len; // see R11
      pwm_on[1] = (frame_cnt_r >= red_len) && (frame_cnt_r < green_end);
      pwm_on[0] = (frame_cnt_r >= green_end) && (frame_cnt_r < blue_end);
    end
  end

  // ==========================================
  // sink drive
  logic ext_level; // filtered dimming pin
  logic [2:0] ch_en; // channel enables, red green blue
  logic [2:0] ext_gate; // external gating per channel
  logic [2:0] sink_nxt; // next sink state

  rlc_sync3 u_dim_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(ext_dim_in),
    .level_out(ext_level)
  );

  assign ch_en = {ctrl_r[RLC_CTL_RED_BIT], ctrl_r[RLC_CTL_GREEN_BIT], ctrl_r[RLC_CTL_BLUE_BIT]};
  assign ext_gate = ~ext_dim_sel_in | {3{ext_level}}; // see R16

  // choose pwm or direct drive, gated by the master enable
  always_comb begin
    if (!ctrl_r[RLC_CTL_EN_BIT]) begin
      sink_nxt = 3'b000; // see R03
    end else if (pwm_act_r) begin
      sink_nxt = ch_en & pwm_on & ext_gate; // see R02 see R04 see R17
    end else begin
      sink_nxt = ch_en & ext_gate; // see R12
    end
  end

  // registered sink and mode outputs
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      red_sink_out <= 1'b0;
      green_sink_out <= 1'b0;
      blue_sink_out <= 1'b0;
      sink_mode_out <= 1'b1;
      red_current_quarters_out <= 3'h1;
      green_current_quarters_out <= 3'h1;
      blue_current_quarters_out <= 3'h1;
    end else begin
      red_sink_out <= sink_nxt[2];
      green_sink_out <= sink_nxt[1];
      blue_sink_out <= sink_nxt[0];
      sink_mode_out <= ctrl_r[RLC_CTL_SINK_BIT]; // see R01
      red_current_quarters_out <= quarters(curr_r[RLC_CUR_RED_LSB +: 2]); // see R15
      green_current_quarters_out <= quarters(curr_r[RLC_CUR_GREEN_LSB +: 2]);
      blue_current_quarters_out <= quarters(curr_r[RLC_CUR_BLUE_LSB +: 2]);
    end
  end

  // ==========================================
  // checks
  logic [2:0] sinks; // sink outputs as a group
  assign sinks = {red_sink_out, green_sink_out, blue_sink_out};

  outputs_off_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // see R03
    !ctrl_r[RLC_CTL_EN_BIT] |=> sinks == 3'b000)
    else $error("sinks on while colour outputs disabled");

  sink_mode_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // see R01
    (reg_wr_in && reg_addr_in == RLC_ADDR_CTRL)
      |-> ##2 sink_mode_out == $past(reg_wdata_in[RLC_CTL_SINK_BIT], 2))
    else $error("sink mode does not follow written bit");

  frame_wrap_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // see R18
    frame_cnt_r == RLC_CNT_W'(FRAME_CYCLES - 1) |=> frame_cnt_r == '0)
    else $error("frame counter did not wrap");

  direct_drive_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // see R12
    (ctrl_r[RLC_CTL_EN_BIT] && !pwm_act_r && ext_dim_sel_in == 3'b000)
      |=> sinks == $past(ch_en))
    else $error("direct mode sinks differ from enable bits");

  bright_zero_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // see R07
    (pwm_act_r && bright_q_r == 3'h0) |=> sinks == 3'b000)
    else $error("sinks on at zero brightness");

  overlap_same_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // see R10
    (ctrl_r[RLC_CTL_EN_BIT] && pwm_act_r && ovl_r && ch_en == 3'b111
     && ext_dim_sel_in == 3'b000)
      |=> (red_sink_out == green_sink_out) && (green_sink_out == blue_sink_out))
    else $error("overlapping channels not switched together");

  slots_apart_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // see R11
    (pwm_act_r && !ovl_r) |=> $onehot0(sinks))
    else $error("non-overlapping slots overlap");

  half_tail_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // see R11
    (pwm_act_r && !ovl_r && bright_q_r == 3'h6
     && frame_cnt_r >= RLC_CNT_W'(FRAME_CYCLES / 2)) |=> sinks == 3'b000)
    else $error("sinks on in second half at half brightness");

  ext_gate_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // see R17
    (ext_dim_sel_in[2] && !ext_level) |=> !red_sink_out)
    else $error("red on while external dimming low");
endmodule

// ### hdl/rlc_pkg.sv
// constants for the colour led pwm control block
// assumes a 40 MHz core clock and an 8-bit register port behind the serial interface
package rlc_pkg;
  // ==========================================
  // register offsets
  localparam logic [7:0] RLC_ADDR_CTRL = 8'h00; // color_output_control
  localparam logic [7:0] RLC_ADDR_COLOR = 8'h01; // color_and_brightness
  localparam logic [7:0] RLC_ADDR_CURR = 8'h02; // channel_current_level

  // ==========================================
  // color_output_control fields
  localparam int RLC_CTL_PWM_BIT = 7; // internal_pwm_enable
  localparam int RLC_CTL_EN_BIT = 6; // color_outputs_enable
  localparam int RLC_CTL_SINK_BIT = 5; // sink_mode_select
  localparam int RLC_CTL_RED_BIT = 3; // red_out_enable
  localparam int RLC_CTL_GREEN_BIT = 2; // green_out_enable
  localparam int RLC_CTL_BLUE_BIT = 1; // blue_out_enable
  localparam int RLC_CTL_OVL_BIT = 0; // overlap_select
  localparam logic [7:0] RLC_CTL_MASK = 8'hEF; // bit 4 reads zero

  // ==========================================
  // color_and_brightness fields
  localparam int RLC_COLOR_LSB = 4; // color code 7:4
  localparam int RLC_BRIGHT_LSB = 1; // brightness code 3:1
  localparam logic [7:0] RLC_COLOR_MASK = 8'hFE; // bit 0 reads zero

  // ==========================================
  // channel_current_level fields
  localparam int RLC_CUR_RED_LSB = 4; // red_current_code 5:4
  localparam int RLC_CUR_GREEN_LSB = 2; // green_current_code 3:2
  localparam int RLC_CUR_BLUE_LSB = 0; // blue_current_code 1:0
  localparam logic [7:0] RLC_CURR_MASK = 8'h3F; // bits 7:6 read zero

  // ==========================================
  // values after reset
  localparam logic [7:0] RLC_CTRL_RST = 8'h20; // switch mode, all else off
  localparam logic [7:0] RLC_COLOR_RST = 8'h00; // red, zero brightness
  localparam logic [7:0] RLC_CURR_RST = 8'h00; // quarter current

  // ==========================================
  // timing
  localparam int RLC_CLK_PERIOD_NS = 25; // core clock period
  localparam int RLC_FRAME_NS = 50000; // pwm frame, 50 us
  localparam int RLC_FRAME_CYC = RLC_FRAME_NS / RLC_CLK_PERIOD_NS; // cycles per frame
  localparam int RLC_CNT_W = 12; // frame counter width
  localparam int RLC_BRIGHT_MAX = 7; // code for full on-time
  localparam int RLC_PCT_FULL = 100; // percent scale of the colour table
endpackage

// ### hdl/rlc_sync3.sv
// three-stage synchroniser with agreement filter for a pin level
// assumes the pin is asynchronous to core_clk_in
module rlc_sync3
  import rlc_pkg::*;
(
  input wire logic core_clk_in, // core clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic pin_in, // raw pin level
  output logic level_out // filtered level
);
  // ==========================================
  // sampling chain
  logic s1_r; // first stage, read by s2_r only
  logic s2_r; // second stage
  logic s3_r; // third stage

  // shift the pin through three flops
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // accept a change once stages two and three agree
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_out <= 1'b0;
    end else if (s2_r == s3_r) begin
      level_out <= s3_r;
    end
  end
endmodule

// ### verification/rlc_led_model.sv
// led sink observer: counts lit cycles of each sink over a window
// assumes sinks are active-high levels sampled on the core clock
module rlc_led_model (
  input wire logic core_clk_in, // core clock
  input wire logic clear_in, // restart the window
  input wire logic red_in, // red sink
  input wire logic green_in, // green sink
  input wire logic blue_in, // blue sink
  output int red_cnt_out, // red lit cycles
  output int green_cnt_out, // green lit cycles
  output int blue_cnt_out, // blue lit cycles
  output int all_cnt_out // cycles with all three lit
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // lit-cycle counters, a high sink means the led conducts
  always @(posedge core_clk_in) begin
    if (clear_in) begin
      red_cnt_out <= 0;
      green_cnt_out <= 0;
      blue_cnt_out <= 0;
      all_cnt_out <= 0;
    end else begin
      // unknown levels never count as lit
      red_cnt_out <= red_cnt_out + int'(red_in === 1'b1);
      green_cnt_out <= green_cnt_out + int'(green_in === 1'b1);
      blue_cnt_out <= blue_cnt_out + int'(blue_in === 1'b1);
      all_cnt_out <= all_cnt_out + int'({red_in, green_in, blue_in} === 3'b111);
    end
  end
endmodule

// ### verification/test_rlc_color_pwm.sv
// bench for the colour led pwm block: register strobes, sinks, dimming pin
// assumes a shortened frame so that per-frame on-times stay quick to count
module test_rlc_color_pwm
  import rlc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // signals
  localparam int FC = 200; // shortened frame
  localparam int RP[16] = '{100, 0, 0, 50, 0, 50, 33, 50, 25, 25, 25, 75, 0, 25, 0, 25};
  localparam int GP[16] = '{0, 100, 0, 50, 50, 0, 33, 25, 50, 50, 25, 25, 75, 75, 25, 0};
  localparam int BP[16] = '{0, 0, 100, 0, 50, 50, 33, 25, 25, 25, 50, 0, 25, 0, 75, 75};
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ext = 1'b0, clr = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [2:0] sel = 3'h0, qr, qg, qb;
  logic rs, gs, bs, mode;
  int cr, cg, cb, ca;
  int err_count = 0, checked = 0;

  // ==========================================
  // clock, design and sink observer
  initial begin
    forever #12.5 clk = ~clk;
  end
  rlc_color_pwm #(.FRAME_CYCLES(FC)) dut (.core_clk_in(clk), .rst_n_in(rst_n),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .ext_dim_in(ext), .ext_dim_sel_in(sel), .red_sink_out(rs),
    .green_sink_out(gs), .blue_sink_out(bs), .sink_mode_out(mode),
    .red_current_quarters_out(qr), .green_current_quarters_out(qg),
    .blue_current_quarters_out(qb));
  rlc_led_model leds (.core_clk_in(clk), .clear_in(clr), .red_in(rs), .green_in(gs),
    .blue_in(bs), .red_cnt_out(cr), .green_cnt_out(cg), .blue_cnt_out(cb), .all_cnt_out(ca));

  // ==========================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // one-cycle read strobe, data looked at once it holds
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    chk(nm, {24'h0, rdata}, {24'h0, exp});
  endtask
  // let new settings reach a frame start, then count one full frame
  task automatic measure();
    repeat (2 * FC + 4) @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    repeat (FC) @(negedge clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================
  // watchdog, about five times the expected run
  initial begin
    #2_000_000;
    err_count++;
    results();
  end

  // ==========================================
  // tests
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    // reset values
    rreg(RLC_ADDR_CTRL, 8'h20, "ctrl");
    rreg(RLC_ADDR_COLOR, 8'h00, "color");
    rreg(RLC_ADDR_CURR, 8'h00, "curr");
    chk("mode", {31'h0, mode}, 32'h1);
    chk("sinks", {29'h0, rs, gs, bs}, 32'h0);
    chk("quarters", {23'h0, qr, qg, qb}, {23'h0, 3'h1, 3'h1, 3'h1});
    $display("test reset done");
    // masks, unmapped place, current codes, direct drive
    wreg(RLC_ADDR_CTRL, 8'hFF);
    rreg(RLC_ADDR_CTRL, 8'hEF, "ctrl");
    wreg(RLC_ADDR_COLOR, 8'hFF);
    rreg(RLC_ADDR_COLOR, 8'hFE, "color");
    wreg(RLC_ADDR_CURR, 8'hFF);
    rreg(RLC_ADDR_CURR, 8'h3F, "curr");
    rreg(8'h03, 8'h00, "unmapped");
    wreg(RLC_ADDR_CURR, 8'h1B);
    @(negedge clk);
    chk("quarters", {23'h0, qr, qg, qb}, {23'h0, 3'h2, 3'h3, 3'h4});
    wreg(RLC_ADDR_CTRL, 8'h4A);
    repeat (2) @(negedge clk);
    chk("mode", {31'h0, mode}, 32'h0);
    chk("sinks", {29'h0, rs, gs, bs}, 32'h5);
    wreg(RLC_ADDR_CTRL, 8'h0E);
    repeat (2) @(negedge clk);
    chk("sinks", {29'h0, rs, gs, bs}, 32'h0);
    $display("test registers done");
    // dimming pin gates the selected channel only
    sel = 3'h4;
    wreg(RLC_ADDR_CTRL, 8'h4E);
    repeat (8) @(negedge clk);
    chk("sinks", {29'h0, rs, gs, bs}, 32'h3);
    ext = 1'b1;
    repeat (8) @(negedge clk);
    chk("sinks", {29'h0, rs, gs, bs}, 32'h7);
    sel = 3'h0;
    $display("test dimming done");
    // every brightness code on the red colour
    wreg(RLC_ADDR_CTRL, 8'hC8);
    for (int b = 0; b < 8; b++) begin
      wreg(RLC_ADDR_COLOR, {4'h0, 3'(b), 1'b0});
      measure();
      chk("red on", cr, (b == 0) ? 0 : (FC >> (7 - b)));
    end
    $display("test brightness done");
    // every colour code, full brightness, never all three lit together
    wreg(RLC_ADDR_CTRL, 8'hCE);
    for (int c = 0; c < 16; c++) begin
      wreg(RLC_ADDR_COLOR, {4'(c), 3'h7, 1'b0});
      measure();
      chk("red on", cr, RP[c] * FC / 100);
      chk("green on", cg, GP[c] * FC / 100);
      chk("blue on", cb, BP[c] * FC / 100);
      chk("together", ca, 0);
    end
    $display("test colours done");
    // overlapping: colour ignored, all on together for the duty
    wreg(RLC_ADDR_CTRL, 8'hCF);
    wreg(RLC_ADDR_COLOR, 8'hFA);
    measure();
    chk("red on", cr, FC >> 2);
    chk("blue on", cb, FC >> 2);
    chk("together", ca, FC >> 2);
    // pwm passes to a dimmed channel only while the pin is high
    sel = 3'h4;
    ext = 1'b0;
    wreg(RLC_ADDR_COLOR, 8'h0E);
    measure();
    chk("red on", cr, 0);
    chk("green on", cg, FC);
    ext = 1'b1;
    measure();
    chk("red on", cr, FC);
    // pwm with outputs disabled stays dark
    wreg(RLC_ADDR_CTRL, 8'h8E);
    measure();
    chk("lit", cr + cg + cb, 0);
    $display("test overlap done");
    results();
  end
endmodule
